// ===== hdl/i2cm_pkg.sv
// Constants and register layout for the I2C master sequencer
// How it works
// RL1 - Setting the acknowledge enable pulls the clock low and puts the acknowledge value out
// RL2 - Software picks acknowledge or not-acknowledge value before starting the acknowledge
// RL3 - Acknowledge: one period, release clock, once high another period, clock low, done
// RL4 - Buffer writes while any sequence runs set write collision and are dropped
// RL5 - Stop enable drives data low; once seen low the baud counter runs down
// RL6 - At stop count end clock is released, data released one period later
// RL7 - Data high with clock high sets stop seen; a period later stop ends, irq set
// RL8 - Reset or port disable stops the port and ends any transfer
// RL9 - Start seen and stop seen clear on reset and while the port is off
// RL10 - Software takes the bus only after a stop or when the bus is idle
// RL11 - A stop seen on a busy bus raises the port interrupt flag
// RL12 - Released data bit read low while clock high means bus collision, port idles
// RL13 - Collision checks cover address, data, start, repeated start and acknowledge
// RL14 - Collision in a transfer halts it, clears buffer full, frees both lines
// RL15 - Collision in a sequence aborts it, frees lines, clears the sequence enables
// RL16 - After collision the lines stay watched; a stop sets the port interrupt flag
// RL17 - A buffer write after collision sends the byte from its first bit
// RL18 - Data or clock already low when a start begins aborts with a collision
// RL19 - Start counts once data is high; clock low while data high is a collision
// RL20 - Data low in first start count drives data early; second count ends clock low
// RL21 - Repeated start: data released, count, clock released; data low then collides
// RL22 - Repeated start second count: data falling is fine, clock falling collides
// RL23 - Both high at timeout: data low, count again, then clock low unconditionally
// RL24 - Baud counter reloads from the baud register; one rollover is one period
// RL25 - Both bus lines pass two flip-flop synchronisers before any use
package i2cm_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_BUF  = 8'h08;
  localparam logic [7:0] OFF_BAUD = 8'h0c;
  // Control register bits
  localparam int C_SEN  = 0;
  localparam int C_RESTART_SEQ_ENABLE = 1;
  localparam int C_PEN  = 2;
  localparam int C_AEN  = 3;
  localparam int C_ADT  = 4;
  localparam int C_EN   = 5;
  // Status register bits
  localparam int S_BF   = 0;
  localparam int S_WRITE_COLLISION_FLAG = 1;
  localparam int S_BCL  = 2;
  localparam int S_IRQ  = 3;
  localparam int S_SDET = 4;
  localparam int S_PDET = 5;
  localparam int S_ACKS = 6;
  localparam int S_BUSY = 7;
  localparam logic [7:0] BAUD_RST = 8'h09;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT  = 4'h8;
endpackage

// ===== hdl/i2cm_top.sv
// I2C master acknowledge, stop, start and arbitration sequencer with APB registers
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ns
module i2cm_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_data_line_in,
  output logic             serial_data_line_out,
  output logic             serial_data_line_oe_n,
  input  wire logic        serial_clock_line_in,
  output logic             serial_clock_line_out,
  output logic             serial_clock_line_oe_n
);
  typedef enum {
    ST_IDLE, ST_CHK, ST_W1, ST_W2, RS_REL, RS_SCLH, RS_W1, RS_W2,
    TX_LOW, TX_HIGH, ACK_LOW, ACK_HIGH, SP_LOW, SP_SCLH, SP_SDAH, SP_FIN
  } i2cm_state_t;

  i2cm_state_t state, next_state;
  logic       start_seq_enable, restart_seq_enable, stop_seq_enable, ack_seq_enable;
  logic       ack_data_value, port_en;
  logic       buffer_full_flag, write_collision_flag, bus_collision_flag, port_irq_flag;
  logic       start_det, stop_det, ack_status;
  logic [7:0] tx_rx_buffer, tx_shift, baud_reload_reg, baud_counter;
  logic [3:0] bit_cnt;
  logic       sda_m, sda_s, sda_d, scl_m, scl_s, scl_d;
  logic       next_sda_oe_n, next_scl_oe_n;
  logic       ev_bcl, ev_irq, ev_pset, bf_clr, ack_cap, bit_inc, hold;
  logic [3:0] clr_seq;
  logic       access, wr, buf_wr, buf_ok, baud_done, bus_start, bus_stop;

  // APB transfer qualifiers
  assign access = psel & penable & pready;
  assign wr     = access & pwrite;
  assign buf_wr = wr & (paddr == i2cm_pkg::OFF_BUF);
  assign buf_ok = buf_wr & (state == ST_IDLE) & port_en;

  // Two stage synchronisers plus a delayed copy for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
    end else begin
      sda_m <= serial_data_line_in; // RL25
      sda_s <= sda_m;
      sda_d <= sda_s;
      scl_m <= serial_clock_line_in; // RL25
      scl_s <= scl_m;
      scl_d <= scl_s;
    end
  end

  // Bus condition detection on the synchronised lines
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  // Baud counter, reloaded on entry to each step and while waiting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_counter <= i2cm_pkg::BAUD_RST;
    end else if (hold || next_state != state) begin
      baud_counter <= baud_reload_reg; // RL24
    end else if (baud_counter != 8'h00) begin
      baud_counter <= baud_counter - 8'h01;
    end
  end
  assign baud_done = (baud_counter == 8'h00) & ~hold;

  // Sequencer next state and line drive
  always_comb begin
    next_state    = state;
    next_sda_oe_n = serial_data_line_oe_n;
    next_scl_oe_n = serial_clock_line_oe_n;
    ev_bcl  = 1'b0;
    ev_irq  = 1'b0;
    ev_pset = 1'b0;
    bf_clr  = 1'b0;
    ack_cap = 1'b0;
    bit_inc = 1'b0;
    hold    = 1'b0;
    clr_seq = 4'h0;
    case (state)
      ST_IDLE: begin
        hold = 1'b1; // Counter stopped while idle
        if (start_seq_enable) begin
          next_state = ST_CHK;
        end else if (restart_seq_enable) begin
          next_state    = RS_REL;
          next_sda_oe_n = 1'b1; // RL21
        end else if (stop_seq_enable) begin
          next_state    = SP_LOW;
          next_sda_oe_n = 1'b0; // RL5
        end else if (ack_seq_enable) begin
          next_state    = ACK_LOW;
          next_scl_oe_n = 1'b0; // RL1
          next_sda_oe_n = ack_data_value; // RL1
        end else if (buffer_full_flag) begin
          next_state = TX_LOW;
        end
      end
      ST_CHK: begin
        if (!sda_s || !scl_s) begin
          ev_bcl = 1'b1; // RL18
        end else begin
          next_state = ST_W1; // RL19
        end
      end
      ST_W1: begin
        if (!scl_s && sda_s) begin
          ev_bcl = 1'b1; // RL19
        end else if (!sda_s || baud_done) begin
          next_state    = ST_W2; // RL20
          next_sda_oe_n = 1'b0;
        end
      end
      ST_W2: begin
        if (baud_done) begin
          next_state    = ST_IDLE; // RL20
          next_scl_oe_n = 1'b0;
          clr_seq[i2cm_pkg::C_SEN] = 1'b1;
          ev_irq = 1'b1;
        end
      end
      RS_REL: begin
        hold = ~sda_s;
        if (baud_done) begin
          next_state    = RS_SCLH; // RL21
          next_scl_oe_n = 1'b1;
        end
      end
      RS_SCLH: begin
        hold = 1'b1;
        if (scl_s && !sda_s) begin
          ev_bcl = 1'b1; // RL21
        end else if (scl_s) begin
          next_state = RS_W1; // RL22
        end
      end
      RS_W1: begin
        if (!scl_s && serial_data_line_oe_n) begin
          ev_bcl = 1'b1; // RL22
        end else if (baud_done) begin
          next_state    = RS_W2; // RL23
          next_sda_oe_n = 1'b0;
        end
      end
      RS_W2: begin
        if (baud_done) begin
          next_state    = ST_IDLE; // RL23
          next_scl_oe_n = 1'b0;
          clr_seq[i2cm_pkg::C_RESTART_SEQ_ENABLE] = 1'b1;
          ev_irq = 1'b1;
        end
      end
      TX_LOW: begin
        // Clock pulled low first, so a restart after a collision sends no false edge
        next_scl_oe_n = 1'b0; // RL17
        if (!serial_clock_line_oe_n) begin
          next_sda_oe_n = (bit_cnt == i2cm_pkg::ACK_BIT) ? 1'b1 : tx_shift[7];
        end
        if (baud_done) begin
          next_state    = TX_HIGH;
          next_scl_oe_n = 1'b1;
        end
      end
      TX_HIGH: begin
        hold = ~scl_s;
        if (scl_s && bit_cnt != i2cm_pkg::ACK_BIT && serial_data_line_oe_n && !sda_s) begin
          ev_bcl = 1'b1; // RL12
        end else if (baud_done) begin
          next_scl_oe_n = 1'b0;
          if (bit_cnt == i2cm_pkg::ACK_BIT) begin
            next_state = ST_IDLE;
            ev_irq     = 1'b1;
          end else begin
            next_state = TX_LOW;
            bit_inc    = 1'b1;
            bf_clr     = (bit_cnt == i2cm_pkg::LAST_BIT);
          end
        end
        ack_cap = scl_s & (bit_cnt == i2cm_pkg::ACK_BIT);
      end
      ACK_LOW: begin
        if (baud_done) begin
          next_state    = ACK_HIGH; // RL3
          next_scl_oe_n = 1'b1;
        end
      end
      ACK_HIGH: begin
        hold = ~scl_s;
        if (scl_s && serial_data_line_oe_n && !sda_s) begin
          ev_bcl = 1'b1; // RL13
        end else if (baud_done) begin
          next_state    = ST_IDLE; // RL3
          next_scl_oe_n = 1'b0;
          clr_seq[i2cm_pkg::C_AEN] = 1'b1;
          ev_irq = 1'b1;
        end
      end
      SP_LOW: begin
        hold = sda_s; // RL5
        if (baud_done) begin
          next_state    = SP_SCLH; // RL6
          next_scl_oe_n = 1'b1;
        end
      end
      SP_SCLH: begin
        hold = ~scl_s;
        if (baud_done) begin
          next_state    = SP_SDAH; // RL6
          next_sda_oe_n = 1'b1;
        end
      end
      SP_SDAH: begin
        hold = 1'b1;
        if (!scl_s) begin
          ev_bcl = 1'b1; // RL15
        end else if (sda_s) begin
          next_state = SP_FIN; // RL7
          ev_pset    = 1'b1;
        end
      end
      SP_FIN: begin
        if (baud_done) begin
          next_state = ST_IDLE; // RL7
          clr_seq[i2cm_pkg::C_PEN] = 1'b1;
          ev_irq = 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Collision frees both lines and aborts everything
    if (ev_bcl) begin
      next_state    = ST_IDLE; // RL15
      next_sda_oe_n = 1'b1;
      next_scl_oe_n = 1'b1;
      clr_seq       = 4'hf;
      bf_clr        = 1'b1; // RL14
    end
    if (!port_en) begin
      next_state    = ST_IDLE; // RL8
      next_sda_oe_n = 1'b1;
      next_scl_oe_n = 1'b1;
    end
  end

  // Sequencer state and pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                  <= ST_IDLE; // RL8
      serial_data_line_oe_n  <= 1'b1;
      serial_clock_line_oe_n <= 1'b1;
      serial_data_line_out   <= 1'b0;
      serial_clock_line_out  <= 1'b0;
    end else begin
      state                  <= next_state;
      serial_data_line_oe_n  <= next_sda_oe_n;
      serial_clock_line_oe_n <= next_scl_oe_n;
      serial_data_line_out   <= 1'b0;
      serial_clock_line_out  <= 1'b0;
    end
  end

  // Byte shifter and bit position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift   <= 8'h00;
      bit_cnt    <= 4'h0;
      ack_status <= 1'b0;
    end else begin
      if (buf_ok) begin
        tx_shift <= pwdata[7:0]; // RL17
        bit_cnt  <= 4'h0; // RL17
      end else if (bit_inc) begin
        tx_shift <= {tx_shift[6:0], 1'b0};
        bit_cnt  <= bit_cnt + 4'h1;
      end
      if (ack_cap) begin
        ack_status <= sda_s;
      end
    end
  end

  // Control bits; sequence enables only taken while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_seq_enable   <= 1'b0;
      restart_seq_enable <= 1'b0;
      stop_seq_enable    <= 1'b0;
      ack_seq_enable     <= 1'b0;
      ack_data_value     <= 1'b0;
      port_en            <= 1'b0;
      baud_reload_reg    <= i2cm_pkg::BAUD_RST;
    end else begin
      if (wr && paddr == i2cm_pkg::OFF_CTRL) begin
        ack_data_value <= pwdata[i2cm_pkg::C_ADT];
        port_en        <= pwdata[i2cm_pkg::C_EN];
      end
      if (wr && paddr == i2cm_pkg::OFF_CTRL && state == ST_IDLE) begin
        start_seq_enable   <= pwdata[i2cm_pkg::C_SEN];
        restart_seq_enable <= pwdata[i2cm_pkg::C_RESTART_SEQ_ENABLE];
        stop_seq_enable    <= pwdata[i2cm_pkg::C_PEN];
        ack_seq_enable     <= pwdata[i2cm_pkg::C_AEN];
      end else begin
        start_seq_enable   <= start_seq_enable & ~clr_seq[i2cm_pkg::C_SEN] & port_en;
        restart_seq_enable <= restart_seq_enable & ~clr_seq[i2cm_pkg::C_RESTART_SEQ_ENABLE] & port_en;
        stop_seq_enable    <= stop_seq_enable & ~clr_seq[i2cm_pkg::C_PEN] & port_en;
        ack_seq_enable     <= ack_seq_enable & ~clr_seq[i2cm_pkg::C_AEN] & port_en;
      end
      if (wr && paddr == i2cm_pkg::OFF_BAUD) begin
        baud_reload_reg <= pwdata[7:0]; // RL24
      end
    end
  end

  // Buffer and flags; hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_rx_buffer         <= 8'h00;
      buffer_full_flag     <= 1'b0;
      write_collision_flag <= 1'b0;
      bus_collision_flag   <= 1'b0;
      port_irq_flag        <= 1'b0;
    end else begin
      if (buf_ok) begin
        tx_rx_buffer <= pwdata[7:0];
      end
      buffer_full_flag <= buf_ok | (buffer_full_flag & ~bf_clr & port_en); // RL14
      if (wr && paddr == i2cm_pkg::OFF_STAT) begin
        write_collision_flag <= write_collision_flag & ~pwdata[i2cm_pkg::S_WRITE_COLLISION_FLAG];
        bus_collision_flag   <= bus_collision_flag & ~pwdata[i2cm_pkg::S_BCL];
        port_irq_flag        <= port_irq_flag & ~pwdata[i2cm_pkg::S_IRQ];
      end
      if (buf_wr && !buf_ok) begin
        write_collision_flag <= 1'b1; // RL4
      end
      if (ev_bcl) begin
        bus_collision_flag <= 1'b1; // RL12
      end
      if (ev_irq || (bus_stop && state == ST_IDLE && start_det)) begin
        port_irq_flag <= 1'b1; // RL11 RL16
      end
    end
  end

  // Bus busy tracking from start and stop conditions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_det <= 1'b0; // RL9
      stop_det  <= 1'b0;
    end else if (!port_en) begin
      start_det <= 1'b0; // RL9
      stop_det  <= 1'b0;
    end else if (bus_start) begin
      start_det <= 1'b1;
      stop_det  <= 1'b0;
    end else if (bus_stop || ev_pset) begin
      start_det <= 1'b0;
      stop_det  <= 1'b1; // RL7
    end
  end

  // APB slave with one wait state and registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        if (paddr == i2cm_pkg::OFF_CTRL) begin
          prdata[5:0] <= {port_en, ack_data_value, ack_seq_enable, stop_seq_enable,
                          restart_seq_enable, start_seq_enable};
        end else if (paddr == i2cm_pkg::OFF_STAT) begin
          prdata[7:0] <= {state != ST_IDLE, ack_status, stop_det, start_det, port_irq_flag,
                          bus_collision_flag, write_collision_flag, buffer_full_flag};
        end else if (paddr == i2cm_pkg::OFF_BUF) begin
          prdata[7:0] <= tx_rx_buffer;
        end else if (paddr == i2cm_pkg::OFF_BAUD) begin
          prdata[7:0] <= baud_reload_reg;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Checks on the sequencer
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_free;
    serial_data_line_oe_n && serial_clock_line_oe_n;
  endsequence
  sequence s_ack_go;
    state == ST_IDLE && port_en && ack_seq_enable && !start_seq_enable
      && !restart_seq_enable && !stop_seq_enable;
  endsequence

  property p_ack_drive;
    s_ack_go |=> !serial_clock_line_oe_n && serial_data_line_oe_n == $past(ack_data_value);
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack start drive wrong"); // RL1

  property p_ack_end;
    state == ACK_HIGH && baud_done && !ev_bcl && port_en
      |=> !serial_clock_line_oe_n && !ack_seq_enable && state == ST_IDLE;
  endproperty
  a_ack_end: assert property (p_ack_end) else $error("ack end wrong"); // RL3

  property p_write_collision_flag;
    buf_wr && state != ST_IDLE |=> write_collision_flag && $stable(tx_rx_buffer);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("write collision missed"); // RL4

  property p_stop_go;
    state == ST_IDLE && port_en && stop_seq_enable && !start_seq_enable && !restart_seq_enable
      |=> !serial_data_line_oe_n && state == SP_LOW;
  endproperty
  a_stop_go: assert property (p_stop_go) else $error("stop did not pull data"); // RL5

  property p_stop_fin;
    state == SP_FIN && baud_done && port_en |=> port_irq_flag && !stop_seq_enable && stop_det;
  endproperty
  a_stop_fin: assert property (p_stop_fin) else $error("stop finish wrong"); // RL7

  property p_off;
    !port_en |=> state == ST_IDLE && !start_det && !stop_det ##0 s_free;
  endproperty
  a_off: assert property (p_off) else $error("disabled port still active"); // RL8

  property p_bcl;
    ev_bcl && port_en |=> bus_collision_flag && state == ST_IDLE && !buffer_full_flag ##0 s_free;
  endproperty
  a_bcl: assert property (p_bcl) else $error("collision not handled"); // RL14

  property p_start_abort;
    state == ST_CHK && port_en && (!sda_s || !scl_s) |=> bus_collision_flag && !start_seq_enable;
  endproperty
  a_start_abort: assert property (p_start_abort) else $error("start abort missed"); // RL18

  property p_bus_stop_irq;
    bus_stop && state == ST_IDLE && start_det |=> port_irq_flag;
  endproperty
  a_bus_stop_irq: assert property (p_bus_stop_irq) else $error("bus stop irq missed"); // RL11
endmodule

// ===== sim/i2cm_bus_partner.sv
// Far-side bus party: addressed receiver that acknowledges, plus a rival master that grabs data
`timescale 1ns/1ns
module i2cm_bus_partner (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_low,
  input  wire logic       grab_sda,
  output logic            sda_pull,
  output logic      [7:0] rx_byte,
  output logic      [7:0] scl_highs
);
  logic [3:0] bit_cnt;
  logic       ack_drv;
  logic       scl_q;

  // One process follows both lines, so each state bit has one driver
  initial begin
    bit_cnt = 4'h0;
    ack_drv = 1'h0;
    rx_byte = 8'h00;
    scl_highs = 8'h00;
    scl_q = 1'h1;
    forever begin
      @(scl or sda);
      if (scl === 1'h1 && scl_q === 1'h0) begin
        // Rising clock: data taken, first bit is the MSB
        scl_highs = scl_highs + 8'h01;
        if (bit_cnt < 4'h8) begin
          rx_byte = {rx_byte[6:0], sda};
          bit_cnt = bit_cnt + 4'h1;
        end else if (bit_cnt == 4'h8) begin
          bit_cnt = 4'h9;
        end
      end else if (scl === 1'h0 && scl_q === 1'h1) begin
        // Falling clock: acknowledge held for the ninth clock only
        if (bit_cnt == 4'h8) begin
          ack_drv = ack_low;
        end else if (bit_cnt == 4'h9) begin
          ack_drv = 1'h0;
          bit_cnt = 4'h0;
        end
      end else if (scl === 1'h1) begin
        // Start or stop on the bus restarts the bit count
        bit_cnt = 4'h0;
        ack_drv = 1'h0;
      end
      scl_q = scl;
    end
  end

  // Open-drain pull: receiver acknowledge or rival master
  assign sda_pull = ack_drv | grab_sda;
endmodule

// ===== sim/i2c_master_ack_stop_arbitration_tb_top.sv
// Self-checking bench for the I2C master sequencer: APB driver, bus wiring, scenarios
`timescale 1ns/1ns
module i2c_master_ack_stop_arbitration_tb_top;
  localparam logic [7:0] ctl_a = i2cm_pkg::OFF_CTRL;
  localparam logic [7:0] sts_a = i2cm_pkg::OFF_STAT;
  localparam logic [7:0] buf_a = i2cm_pkg::OFF_BUF;
  localparam logic [7:0] bau_a = i2cm_pkg::OFF_BAUD;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0]  paddr, rx_byte, scl_highs, b, ahs;
  logic [31:0] pwdata, prdata, rd;
  logic        sda_out, sda_oe_n, scl_out, scl_oe_n, sda_pull, ack_low, grab_sda;
  int          failures, checked, seed;
  // Wired-AND lines with pull-ups
  wire logic   sda_line = ~(~sda_oe_n | sda_pull);
  wire logic   scl_line = scl_oe_n;

  i2cm_top i2cm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_data_line_in(sda_line), .serial_data_line_out(sda_out), .serial_data_line_oe_n(sda_oe_n),
    .serial_clock_line_in(scl_line), .serial_clock_line_out(scl_out), .serial_clock_line_oe_n(scl_oe_n));
  i2cm_bus_partner i2cm_bus_partner_inst (.scl(scl_line), .sda(sda_line), .ack_low(ack_low),
    .grab_sda(grab_sda), .sda_pull(sda_pull), .rx_byte(rx_byte), .scl_highs(scl_highs));

  // System clock, 8 ns
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [31:0] bv(int i);
    return 32'h0000_0001 << i;
  endfunction

  // Acknowledge status expected from the receiver's answer
  function automatic logic exp_acks(logic low);
    return ~low;
  endfunction

  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer, held until pready
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 40);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 40) begin
      failures++;
      summarize();
    end
  endtask

  // Poll a register bit with a bound
  task automatic wait_bit(logic [7:0] a, int i, logic v);
    int n;
    n = 0;
    do begin
      apb(1'h0, a, 32'h0000_0000);
      n++;
    end while (rd[i] !== v && n < 3000);
    if (n >= 3000) begin
      failures++;
      summarize();
    end
  endtask

  task automatic start_seq();
    apb(1'h1, ctl_a, bv(i2cm_pkg::C_EN) | bv(i2cm_pkg::C_SEN));
    wait_bit(ctl_a, i2cm_pkg::C_SEN, 1'h0);
  endtask

  // Send one byte, compare what the receiver got
  task automatic xfer(logic [7:0] v);
    apb(1'h1, buf_a, {24'h00_0000, v});
    wait_bit(sts_a, i2cm_pkg::S_IRQ, 1'h1);
    chk("rx_byte", v, rx_byte);
    chk("ack_status", exp_acks(ack_low), rd[i2cm_pkg::S_ACKS]);
    apb(1'h1, sts_a, 32'h0000_000e);
  endtask

  initial begin
    seed = 32'h531c;
    failures = 0;
    checked = 0;
    {psel, penable, pwrite, ack_low, grab_sda, presetn} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    cyc(2);
    presetn <= 1'h1;
    chk("reset lines", 4'h3, {sda_out, scl_out, sda_oe_n, scl_oe_n});
    apb(1'h0, sts_a, 32'h0000_0000);
    chk("reset status", 32'h0000_0000, rd);
    apb(1'h0, bau_a, 32'h0000_0000);
    chk("baud reset", i2cm_pkg::BAUD_RST, rd);
    apb(1'h0, 8'h10, 32'h0000_0000);
    chk("unmapped err", 1'h1, last_err);
    apb(1'h1, bau_a, 32'h0000_0003);
    apb(1'h1, ctl_a, bv(i2cm_pkg::C_EN));
    apb(1'h0, sts_a, 32'h0000_0000);
    chk("idle detect", 2'h0, rd[i2cm_pkg::S_PDET:i2cm_pkg::S_SDET]);
    start_seq();
    chk("start scl low", 1'h0, scl_oe_n);
    apb(1'h0, sts_a, 32'h0000_0000);
    chk("start det", 1'h1, rd[i2cm_pkg::S_SDET]);
    apb(1'h1, sts_a, 32'h0000_000e);
    // Random bytes with random answers
    for (int k = 0; k < 3; k++) begin
      b = 8'($random(seed));
      ack_low <= 1'($random(seed));
      xfer(b);
    end
    // Acknowledge sequence, not-acknowledge first
    for (int a = 1; a >= 0; a--) begin
      ahs = scl_highs;
      apb(1'h1, ctl_a, bv(i2cm_pkg::C_EN) | bv(i2cm_pkg::C_AEN) | (a << i2cm_pkg::C_ADT));
      cyc(2);
      chk("ack data", a, sda_oe_n);
      chk("ack scl", 1'h0, scl_oe_n);
      wait_bit(ctl_a, i2cm_pkg::C_AEN, 1'h0);
      chk("ack pulses", ahs + 8'h01, scl_highs);
      chk("ack end scl", 1'h0, scl_oe_n);
    end
    // Stop, with a buffer write landing inside it
    apb(1'h1, sts_a, 32'h0000_000e);
    apb(1'h1, ctl_a, bv(i2cm_pkg::C_EN) | bv(i2cm_pkg::C_PEN));
    cyc(2);
    chk("stop sda low", 1'h0, sda_oe_n);
    apb(1'h1, buf_a, 32'h0000_003c);
    apb(1'h0, sts_a, 32'h0000_0000);
    chk("write_collision_flag", 1'h1, rd[i2cm_pkg::S_WRITE_COLLISION_FLAG]);
    apb(1'h0, buf_a, 32'h0000_0000);
    chk("buf kept", {24'h00_0000, b}, rd);
    wait_bit(ctl_a, i2cm_pkg::C_PEN, 1'h0);
    apb(1'h0, sts_a, 32'h0000_0000);
    chk("stop det", 1'h1, rd[i2cm_pkg::S_PDET]);
    chk("stop irq", 1'h1, rd[i2cm_pkg::S_IRQ]);
    chk("stop lines", 2'h3, {sda_oe_n, scl_oe_n});
    // Port off clears detect bits
    apb(1'h1, ctl_a, 32'h0000_0000);
    apb(1'h0, sts_a, 32'h0000_0000);
    chk("det off", 2'h0, rd[i2cm_pkg::S_PDET:i2cm_pkg::S_SDET]);
    apb(1'h1, sts_a, 32'h0000_000e);
    apb(1'h1, ctl_a, bv(i2cm_pkg::C_EN));
    // Rival master pulls data during a released bit
    start_seq();
    apb(1'h1, buf_a, 32'h0000_00ff);
    cyc(40);
    grab_sda <= 1'h1;
    wait_bit(sts_a, i2cm_pkg::S_BCL, 1'h1);
    chk("bcl bf", 1'h0, rd[i2cm_pkg::S_BF]);
    cyc(4);
    chk("bcl lines", 2'h3, {sda_oe_n, scl_oe_n});
    apb(1'h0, ctl_a, 32'h0000_0000);
    chk("bcl seq bits", 4'h0, rd[3:0]);
    apb(1'h1, sts_a, 32'h0000_000e);
    grab_sda <= 1'h0;
    cyc(20);
    apb(1'h0, sts_a, 32'h0000_0000);
    chk("bus stop irq", 1'h1, rd[i2cm_pkg::S_IRQ]);
    apb(1'h1, sts_a, 32'h0000_000e);
    ack_low <= 1'h1;
    xfer(8'ha5);
    // Repeated start ends with both lines held low
    apb(1'h1, ctl_a, bv(i2cm_pkg::C_EN) | bv(i2cm_pkg::C_RESTART_SEQ_ENABLE));
    wait_bit(ctl_a, i2cm_pkg::C_RESTART_SEQ_ENABLE, 1'h0);
    chk("restart lines", 2'h0, {sda_oe_n, scl_oe_n});
    apb(1'h1, ctl_a, bv(i2cm_pkg::C_EN) | bv(i2cm_pkg::C_PEN));
    wait_bit(ctl_a, i2cm_pkg::C_PEN, 1'h0);
    // Start attempted while data is already low
    grab_sda <= 1'h1;
    cyc(8);
    apb(1'h1, sts_a, 32'h0000_000e);
    start_seq();
    apb(1'h0, sts_a, 32'h0000_0000);
    chk("start bcl", 1'h1, rd[i2cm_pkg::S_BCL]);
    chk("start lines", 2'h3, {sda_oe_n, scl_oe_n});
    grab_sda <= 1'h0;
    cyc(8);
    // Reset in mid byte
    apb(1'h1, buf_a, 32'h0000_0096);
    cyc(30);
    presetn <= 1'h0;
    cyc(1);
    chk("reset mid lines", 2'h3, {sda_oe_n, scl_oe_n});
    presetn <= 1'h1;
    apb(1'h0, ctl_a, 32'h0000_0000);
    chk("reset mid ctrl", 32'h0000_0000, rd);
    summarize();
  end
endmodule
